// *** inc/ecs_consts.svh ***
// Constants for the EEPROM controller status block
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define ECS_ADDR_W 16
`define ECS_DATA_W 8
`define ECS_ADDR_RST 16'h0000
`define ECS_DATA_RST 8'h00
`define ECS_LAST_LOC 16'hFFFF

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ECS_CLK_MHZ 250
`define ECS_WRITE_WAIT_US 30000
`define ECS_STRETCH_US 30000
`define ECS_ACQUIRE_US 1920000
`define ECS_WRITE_WAIT_CYC (`ECS_WRITE_WAIT_US * `ECS_CLK_MHZ)
`define ECS_STRETCH_CYC (`ECS_STRETCH_US * `ECS_CLK_MHZ)
`define ECS_ACQUIRE_CYC (`ECS_ACQUIRE_US * `ECS_CLK_MHZ)

`endif

// *** inc/ecs_pkg.sv ***
// Types of the EEPROM controller status block
`include "ecs_consts.svh"

package ecs_pkg;

  typedef enum logic [1:0] {
    ECS_OP_READ = 2'h0,
    ECS_OP_WRITE = 2'h1,
    ECS_OP_RSVD2 = 2'h2,
    ECS_OP_RSVD3 = 2'h3
  } ecs_op_type;

  typedef enum logic [1:0] {
    ECS_IDLE = 2'b00,
    ECS_ACQ = 2'b01,
    ECS_XFER = 2'b10,
    ECS_WRWAIT = 2'b11
  } ecs_state_type;

  typedef struct packed {
    logic request;
    logic write;
    logic [`ECS_ADDR_W-1:0] location;
    logic [`ECS_DATA_W-1:0] wdata;
  } ecs_link_req_type;

  typedef struct packed {
    logic opTimeout;
    logic loaderOverrun;
    logic imageLoaded;
  } ecs_flags_type;

endpackage

// *** hdl/ecs_timer.sv ***
// Timeout counter with restart
`timescale 1ns/1ps

module ecs_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic restart,
  input wire logic [WIDTH-1:0] limit,
  output logic expired
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // ---------------------------------------------------------------
  // Count while running
  // ---------------------------------------------------------------
  assign expired = run && (count_q == limit - WIDTH'(1));

  always_comb begin
    if (!run || restart || expired) begin
      count_d = '0;
    end else begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// *** hdl/ecs_status.sv ***
// EEPROM controller operation sequencing and status flags
`timescale 1ns/1ps
`include "ecs_consts.svh"

module ecs_status
  import ecs_pkg::*;
#(
  parameter int unsigned WRITE_WAIT_CYCLES = `ECS_WRITE_WAIT_CYC,
  parameter int unsigned STRETCH_CYCLES = `ECS_STRETCH_CYC,
  parameter int unsigned ACQUIRE_CYCLES = `ECS_ACQUIRE_CYC,
  parameter logic [`ECS_ADDR_W-1:0] LAST_LOC = `ECS_LAST_LOC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic opStart,
  input wire ecs_op_type eeprom_op_code,
  input wire logic locationWrite,
  input wire logic [`ECS_ADDR_W-1:0] locationIn,
  input wire logic dataWrite,
  input wire logic [`ECS_DATA_W-1:0] dataIn,
  input wire logic timeoutClear,
  input wire logic loadedClear,
  input wire logic loaderRestart,
  input wire logic loaderReadReq,
  input wire logic [`ECS_ADDR_W:0] loaderReadAddr,
  input wire logic loadDoneOk,
  input wire logic linkGrant,
  input wire logic linkAckMissing,
  input wire logic linkDone,
  input wire logic [`ECS_DATA_W-1:0] linkRData,
  input wire logic writeAcked,
  input wire logic sclPin,
  output logic busy,
  output logic [`ECS_ADDR_W-1:0] eeprom_byte_location,
  output logic [`ECS_DATA_W-1:0] dataOut,
  output ecs_link_req_type linkReq,
  output ecs_flags_type flags
);

  ecs_state_type state_q;
  ecs_state_type state_d;
  ecs_link_req_type linkReq_q;
  ecs_link_req_type linkReq_d;
  ecs_flags_type flags_q;
  ecs_flags_type flags_d;
  logic [`ECS_ADDR_W-1:0] location_q;
  logic [`ECS_ADDR_W-1:0] location_d;
  logic [`ECS_DATA_W-1:0] data_q;
  logic [`ECS_DATA_W-1:0] data_d;
  logic sclMeta_q;
  logic sclSync_q;
  logic sclLow;
  logic timerRun;
  logic timerRestart;
  logic timerExpired;
  logic [31:0] timerLimit;
  logic timeoutEvent;
  logic overrunEvent;
  logic unsupported;

  // ---------------------------------------------------------------
  // Clock line synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
    end else begin
      sclMeta_q <= sclPin;
      sclSync_q <= sclMeta_q;
    end
  end

  assign sclLow = !sclSync_q;

  // ---------------------------------------------------------------
  // Shared timeout timer
  // ---------------------------------------------------------------
  always_comb begin
    timerRun = 1'b0;
    timerLimit = WRITE_WAIT_CYCLES;
    case (state_q)
      ECS_ACQ: begin
        timerRun = 1'b1;
        timerLimit = ACQUIRE_CYCLES;
      end
      ECS_XFER: begin
        timerRun = sclLow;
        timerLimit = STRETCH_CYCLES;
      end
      ECS_WRWAIT: begin
        timerRun = 1'b1;
        timerLimit = WRITE_WAIT_CYCLES;
      end
      default: begin
        timerRun = 1'b0;
      end
    endcase
  end

  assign timerRestart = (state_d != state_q);

  ecs_timer #(
    .WIDTH(32)
  ) ecs_timer_i (
    .clock(clock),
    .reset(reset),
    .run(timerRun),
    .restart(timerRestart),
    .limit(timerLimit),
    .expired(timerExpired)
  );

  // ---------------------------------------------------------------
  // Operation sequencer
  // ---------------------------------------------------------------
  assign unsupported = (eeprom_op_code != ECS_OP_READ) && (eeprom_op_code != ECS_OP_WRITE);

  always_comb begin
    state_d = state_q;
    linkReq_d = linkReq_q;
    location_d = location_q;
    data_d = data_q;
    timeoutEvent = 1'b0;
    if (locationWrite && state_q == ECS_IDLE) begin
      location_d = locationIn;
    end
    if (dataWrite && state_q == ECS_IDLE) begin
      data_d = dataIn;
    end
    case (state_q)
      ECS_IDLE: begin
        linkReq_d.request = 1'b0;
        if (opStart) begin
          if (unsupported) begin
            timeoutEvent = 1'b1;
          end else begin
            state_d = ECS_ACQ;
            linkReq_d.request = 1'b1;
            linkReq_d.write = (eeprom_op_code == ECS_OP_WRITE);
            linkReq_d.location = location_d;
            linkReq_d.wdata = data_d;
          end
        end
      end
      ECS_ACQ: begin
        if (linkGrant) begin
          state_d = ECS_XFER;
        end else if (timerExpired) begin
          timeoutEvent = 1'b1;
          state_d = ECS_IDLE;
          linkReq_d.request = 1'b0;
        end
      end
      ECS_XFER: begin
        if (linkAckMissing || timerExpired) begin
          timeoutEvent = 1'b1;
          state_d = ECS_IDLE;
          linkReq_d.request = 1'b0;
        end else if (linkDone) begin
          linkReq_d.request = 1'b0;
          if (linkReq_q.write) begin
            state_d = ECS_WRWAIT;
          end else begin
            data_d = linkRData;
            state_d = ECS_IDLE;
          end
        end
      end
      ECS_WRWAIT: begin
        if (writeAcked) begin
          state_d = ECS_IDLE;
        end else if (timerExpired) begin
          timeoutEvent = 1'b1;
          state_d = ECS_IDLE;
        end
      end
      default: begin
        state_d = ECS_IDLE;
        linkReq_d.request = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  assign overrunEvent = loaderReadReq && (loaderReadAddr > {1'b0, LAST_LOC});

  always_comb begin
    flags_d = flags_q;
    flags_d.opTimeout = timeoutEvent || (flags_q.opTimeout && !timeoutClear);
    flags_d.loaderOverrun = overrunEvent || (flags_q.loaderOverrun && !loaderRestart);
    flags_d.imageLoaded = loadDoneOk || (flags_q.imageLoaded && !loaderRestart && !loadedClear);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ECS_IDLE;
      linkReq_q <= '0;
      flags_q <= '0;
      location_q <= `ECS_ADDR_RST;
      data_q <= `ECS_DATA_RST;
    end else begin
      state_q <= state_d;
      linkReq_q <= linkReq_d;
      flags_q <= flags_d;
      location_q <= location_d;
      data_q <= data_d;
    end
  end

  assign busy = (state_q != ECS_IDLE);
  assign eeprom_byte_location = location_q;
  assign dataOut = data_q;
  assign linkReq = linkReq_q;
  assign flags = flags_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_overrun_set;
    @(posedge clock) disable iff (reset)
    overrunEvent |=> flags.loaderOverrun;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun flag not set");

  property p_overrun_clr;
    @(posedge clock) disable iff (reset)
    loaderRestart && !overrunEvent |=> !flags.loaderOverrun;
  endproperty
  a_overrun_clr: assert property (p_overrun_clr) else $error("overrun flag not cleared");

  property p_write_timeout;
    @(posedge clock) disable iff (reset)
    state_q == ECS_XFER && linkDone && linkReq.write && !linkAckMissing && !timerExpired ##1
      !writeAcked [*8] |-> state_q == ECS_WRWAIT && busy;
  endproperty
  a_write_timeout: assert property (p_write_timeout) else $error("write wait ended early");

  property p_ack_missing;
    @(posedge clock) disable iff (reset)
    state_q == ECS_XFER && linkAckMissing |=> flags.opTimeout && state_q == ECS_IDLE && !linkReq.request;
  endproperty
  a_ack_missing: assert property (p_ack_missing) else $error("missing ack not reported");

  property p_stretch;
    @(posedge clock) disable iff (reset)
    state_q == ECS_XFER && timerExpired |=> flags.opTimeout && state_q == ECS_IDLE;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock stretch not reported");

  property p_acquire;
    @(posedge clock) disable iff (reset)
    state_q == ECS_ACQ && timerExpired && !linkGrant |=> flags.opTimeout && state_q == ECS_IDLE;
  endproperty
  a_acquire: assert property (p_acquire) else $error("bus acquire timeout missed");

  property p_unsupported;
    @(posedge clock) disable iff (reset)
    state_q == ECS_IDLE && opStart && unsupported |=> flags.opTimeout && state_q == ECS_IDLE && !linkReq.request;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("unsupported code accessed");

  property p_loaded;
    @(posedge clock) disable iff (reset)
    (loadDoneOk |=> flags.imageLoaded) and ((loaderRestart || loadedClear) && !loadDoneOk |=> !flags.imageLoaded);
  endproperty
  a_loaded: assert property (p_loaded) else $error("image loaded flag wrong");

  property p_read_data;
    @(posedge clock) disable iff (reset)
    state_q == ECS_XFER && linkDone && !linkAckMissing && !timerExpired && !linkReq.write
      |=> dataOut == $past(linkRData) && state_q == ECS_IDLE;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read byte not captured");

  c_write_done: cover property (@(posedge clock) disable iff (reset) state_q == ECS_WRWAIT && writeAcked);
  c_read_done: cover property (@(posedge clock) disable iff (reset) state_q == ECS_XFER && linkDone && !linkReq.write);
  c_acq_timeout: cover property (@(posedge clock) disable iff (reset) state_q == ECS_ACQ && timerExpired);
  c_overrun: cover property (@(posedge clock) disable iff (reset) overrunEvent);

endmodule

// *** tb/ecs_link_model.sv ***
// Far-side model of the I2C link and serial EEPROM
`timescale 1ns/1ps

module ecs_link_model
  import ecs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire ecs_link_req_type linkReq,
  input wire logic [2:0] mode,
  output logic linkGrant,
  output logic linkAckMissing,
  output logic linkDone,
  output logic [7:0] linkRData,
  output logic writeAcked,
  output logic sclPin
);
  logic [1:0] phase = 2'h0;
  logic [3:0] cnt = 4'h0;
  logic isWrite = 1'b0;
  always @(negedge clock) begin
    {linkGrant, linkAckMissing, linkDone, writeAcked} <= 4'h0;
    sclPin <= 1'b1;
    linkRData <= ~linkRData;
    cnt <= cnt + 4'h1;
    if (reset) begin
      phase <= 2'h0;
      cnt <= 4'h0;
      linkRData <= 8'h00;
    end else case (phase)
      2'h0: if (!linkReq.request) cnt <= 4'h0;
      else if (cnt == 4'h2 && mode != 3'h1) begin
        linkGrant <= 1'b1;
        isWrite <= linkReq.write;
        phase <= 2'h1;
        cnt <= 4'h0;
      end
      2'h1: if (!linkReq.request) phase <= 2'h0;
      else if (mode == 3'h4) sclPin <= 1'b0;
      else if (cnt == 4'h3) begin
        // ack withheld on command, else byte returned
        if (mode == 3'h2) linkAckMissing <= 1'b1;
        else begin
          linkDone <= 1'b1;
          linkRData <= ~linkReq.location[7:0];
        end
        phase <= (isWrite && mode != 3'h2) ? 2'h2 : 2'h0;
        cnt <= 4'h0;
      end
      default: if (cnt == 4'h3) begin
        writeAcked <= (mode != 3'h3);
        phase <= 2'h0;
      end
    endcase
  end
endmodule

// *** tb/ecs_status_tb.sv ***
// Self-checking bench of the EEPROM controller status block
`timescale 1ns/1ps

module ecs_status_tb;
  import ecs_pkg::*;
  localparam int WW = 20, SC = 20, AQ = 30;
  logic clock = 1'b0, reset = 1'b1, opStart = 1'b0, locWr = 1'b0;
  logic linkGrant, linkAckMissing, linkDone, writeAcked, sclPin, busy;
  logic [4:0] ctl = 5'h00;
  logic timeoutClear, loadedClear, loaderRestart, loaderReadReq, loadDoneOk;
  logic [15:0] locationIn = 16'h0000, loc;
  logic [16:0] loaderReadAddr = 17'h00000;
  logic [7:0] dataIn = 8'h00, dataOut, linkRData;
  logic [2:0] mode = 3'h0;
  ecs_op_type opCode = ECS_OP_READ;
  ecs_link_req_type linkReq;
  ecs_flags_type flags;
  int error_cnt = 0, cmp_count = 0, n;
  assign {timeoutClear, loadedClear, loaderRestart, loaderReadReq, loadDoneOk} = ctl;

  always #2 clock = ~clock;

  ecs_status #(.WRITE_WAIT_CYCLES(WW), .STRETCH_CYCLES(SC), .ACQUIRE_CYCLES(AQ)) ecs_status_i (
    .clock(clock), .reset(reset), .opStart(opStart), .eeprom_op_code(opCode), .locationWrite(locWr),
    .locationIn(locationIn), .dataWrite(locWr), .dataIn(dataIn), .timeoutClear(timeoutClear),
    .loadedClear(loadedClear), .loaderRestart(loaderRestart), .loaderReadReq(loaderReadReq),
    .loaderReadAddr(loaderReadAddr), .loadDoneOk(loadDoneOk), .linkGrant(linkGrant),
    .linkAckMissing(linkAckMissing), .linkDone(linkDone), .linkRData(linkRData), .writeAcked(writeAcked),
    .sclPin(sclPin), .busy(busy), .eeprom_byte_location(loc), .dataOut(dataOut), .linkReq(linkReq),
    .flags(flags));

  ecs_link_model ecs_link_model_i (
    .clock(clock), .reset(reset), .linkReq(linkReq), .mode(mode), .linkGrant(linkGrant),
    .linkAckMissing(linkAckMissing), .linkDone(linkDone), .linkRData(linkRData),
    .writeAcked(writeAcked), .sclPin(sclPin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic pulse(input logic [4:0] v);
    @(negedge clock) ctl = v;
    @(negedge clock) ctl = 5'h00;
  endtask

  task automatic run_op(input ecs_op_type c);
    @(negedge clock) opCode = c;
    opStart = 1'b1;
    @(negedge clock) opStart = 1'b0;
    chk("busy", 17'(c == ECS_OP_READ || c == ECS_OP_WRITE), busy);
    chk("request", 17'(c == ECS_OP_READ || c == ECS_OP_WRITE), linkReq.request);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clock) n++;
    end
    if (n >= 300) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_data();
    chk("reset location", 17'h0000, loc);
    chk("reset flags", 17'h0, flags);
    @(negedge clock) {locWr, locationIn, dataIn} = {1'b1, 16'h1234, 8'hA5};
    @(negedge clock) locWr = 1'b0;
    run_op(ECS_OP_WRITE);
    chk("write data", 17'hA5, dataOut);
    chk("write timeout", 17'h0, flags.opTimeout);
    chk("link location", 17'h1234, linkReq.location);
    chk("link wdata", 17'hA5, linkReq.wdata);
    chk("link write", 17'h1, linkReq.write);
    run_op(ECS_OP_READ);
    chk("link read", 17'h0, linkReq.write);
    chk("read data", 17'hCB, dataOut);
    chk("location", 17'h1234, loc);
    $display("test data done");
  endtask

  task automatic t_unsup();
    for (int c = 2; c < 4; c++) begin
      run_op(ecs_op_type'(c));
      chk("unsupported access", 17'h0, 17'(n));
      chk("unsupported flag", 17'h1, flags.opTimeout);
      pulse(5'h10);
      chk("flag cleared", 17'h0, flags.opTimeout);
    end
    $display("test unsupported done");
  endtask

  task automatic t_tmo();
    int lim[5] = '{0, AQ, 0, WW, SC};
    for (int m = 1; m < 5; m++) begin
      mode = 3'(m);
      run_op(ECS_OP_WRITE);
      chk("timeout flag", 17'h1, flags.opTimeout);
      chk("timeout span", 17'h1, n >= lim[m] && n <= lim[m] + 12);
      pulse(5'h10);
    end
    mode = 3'h0;
    run_op(ECS_OP_WRITE);
    chk("clean write", 17'h0, flags.opTimeout);
    $display("test timeouts done");
  endtask

  task automatic t_loader();
    loaderReadAddr = 17'h0FFFF;
    pulse(5'h02);
    chk("overrun at last", 17'h0, flags.loaderOverrun);
    loaderReadAddr = 17'h10000;
    pulse(5'h02);
    chk("overrun past end", 17'h1, flags.loaderOverrun);
    pulse(5'h04);
    chk("overrun restart", 17'h0, flags.loaderOverrun);
    pulse(5'h01);
    chk("loaded set", 17'h1, flags.imageLoaded);
    pulse(5'h08);
    chk("loaded w1c", 17'h0, flags.imageLoaded);
    pulse(5'h01);
    pulse(5'h04);
    chk("loaded restart", 17'h0, flags.imageLoaded);
    pulse(5'h01);
    n = 0;
    while (flags.imageLoaded !== 1'b1 && n < 50) begin
      @(negedge clock) n++;
    end
    chk("load polled", 17'h1, flags.imageLoaded);
    pulse(5'h02);
    chk("overrun before reset", 17'h1, flags.loaderOverrun);
    @(negedge clock) reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    chk("overrun reset", 17'h0, flags.loaderOverrun);
    chk("loaded reset", 17'h0, flags.imageLoaded);
    $display("test loader done");
  endtask

  initial begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    t_data();
    t_unsup();
    t_tmo();
    t_loader();
    print_verdict();
  end
endmodule
